// *** hw/can_guard_pkg.sv ***
package can_guard_pkg;
	// register byte addresses on the plain write and read ports
	localparam logic [7:0] ADDR_BTR_LO = 8'h00;
	localparam logic [7:0] ADDR_BTR_HI = 8'h01;
	localparam logic [7:0] ADDR_FCR_A = 8'h02;
	localparam logic [7:0] ADDR_FCR_B = 8'h03;
	localparam logic [7:0] ADDR_FMR = 8'h04;
	localparam logic [7:0] ADDR_DIAG = 8'h05;
	localparam logic [7:0] ADDR_RFR = 8'h06;
	localparam logic [7:0] ADDR_MSR = 8'h07;
	localparam logic [7:0] ADDR_FILT_BASE = 8'h10;
	localparam logic [7:0] ADDR_MBOX_BASE = 8'h20;
	// field positions
	localparam int RFR_RELEASE_BIT = 5;
	localparam int MSR_RECEIVING_BIT = 5;
	localparam int MSR_INIT_BIT = 0;
	localparam int DIAG_RX_BIT = 3;
	// reset values and fifo count limit
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] COUNT_RESET = 2'h0;
	localparam logic [1:0] COUNT_MAX = 2'h3;
	// frame tail timing, in bit times and cpu cycles
	localparam int BIT_CYCLES_MAX_RATE = 8;
	localparam int SAMPLE_POINT_CYCLES = 4;
	localparam int XFER_BITS = 6;
	localparam int END_BITS = 8;
	// reception tracker states
	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_FRAME = 3'b010,
		RX_TAIL = 3'b100
	} rx_state_t;
endpackage

// *** hw/rx_fifo_mem.sv ***
`timescale 1ns/100ps
`default_nettype none
module rx_fifo_mem #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 3,
	parameter int AW = 2
) (
	// clock
	input wire logic ref_clk_i,
	// write port
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	// read port, data registered
	input wire logic [AW-1:0] rd_addr_i,
	output logic [WIDTH-1:0] rd_data_o
);
	logic [WIDTH-1:0] mem [DEPTH];

	// storage write
	always_ff @(posedge ref_clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	// write-through so a message landing in an empty fifo shows at once
	always_ff @(posedge ref_clk_i) begin
		if (wr_en_i && (wr_addr_i == rd_addr_i)) begin
			rd_data_o <= wr_data_i;
		end else begin
			rd_data_o <= mem[rd_addr_i];
		end
	end
endmodule
`default_nettype wire

// *** hw/can_config_guard_rx_fifo_release.sv ***
`timescale 1ns/100ps
`default_nettype none
module can_config_guard_rx_fifo_release
	import can_guard_pkg::*;
#(
	parameter int BIT_CYCLES = BIT_CYCLES_MAX_RATE,
	parameter int NUM_FILTERS = 2,
	parameter int NUM_MBOX = 2,
	parameter int MSG_W = 64
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// software register port
	input wire logic wr_en_i,
	input wire logic [7:0] wr_addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic [7:0] rd_addr_i,
	output logic [7:0] rd_data_o,
	// controller state
	input wire logic init_mode_i,
	input wire logic [NUM_MBOX-1:0] mbox_empty_i,
	input wire logic [NUM_FILTERS-1:0] filter_active_i,
	// bit stream events, same clock
	input wire logic rx_sof_i,
	input wire logic rx_ack_i,
	input wire logic [MSG_W-1:0] rx_msg_i,
	// receive pin, asynchronous
	input wire logic rx_pin_i,
	// configuration outputs
	output logic [7:0] bit_timing_reg_low_o,
	output logic [7:0] bit_timing_reg_high_o,
	output logic [7:0] filter_config_reg_a_o,
	output logic [7:0] filter_config_reg_b_o,
	output logic [7:0] filter_mode_reg_o,
	output logic [7:0] diagnostic_reg_o,
	output logic [8*NUM_FILTERS-1:0] filter_value_o,
	output logic [8*NUM_MBOX-1:0] mbox_data_o,
	// receive side outputs
	output logic [1:0] fifo_pending_count_o,
	output logic receiving_flag_o,
	output logic [MSG_W-1:0] fifo_out_msg_o
);
	localparam int XFER_AT = XFER_BITS * BIT_CYCLES + SAMPLE_POINT_CYCLES;
	localparam int END_AT = END_BITS * BIT_CYCLES;
	localparam int CW = $clog2(END_AT + 1);

	logic rx_meta_q, rx_sync_q;
	rx_state_t state_q;
	logic [CW-1:0] tail_cnt_q;
	logic [1:0] count_q, rd_ptr_q, wr_ptr_q;
	logic xfer, release_req, push, pop;
	logic [1:0] rd_ptr_d;
	logic [7:0] rd_data_d;

	// two-flop synchroniser on the pin; the fixed lag keeps software's polling bound
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			rx_meta_q <= 1'b1;
			rx_sync_q <= 1'b1;
		end else begin
			rx_meta_q <= rx_pin_i;
			rx_sync_q <= rx_meta_q;
		end
	end

	// configuration registers locked outside init mode
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			bit_timing_reg_low_o <= REG_RESET;
			bit_timing_reg_high_o <= REG_RESET;
			filter_config_reg_a_o <= REG_RESET;
			filter_config_reg_b_o <= REG_RESET;
			filter_mode_reg_o <= REG_RESET;
			diagnostic_reg_o <= REG_RESET;
		end else if (wr_en_i && init_mode_i) begin
			if (wr_addr_i == ADDR_BTR_LO) begin
				bit_timing_reg_low_o <= wr_data_i;
			end else if (wr_addr_i == ADDR_BTR_HI) begin
				bit_timing_reg_high_o <= wr_data_i;
			end else if (wr_addr_i == ADDR_FCR_A) begin
				filter_config_reg_a_o <= wr_data_i;
			end else if (wr_addr_i == ADDR_FCR_B) begin
				filter_config_reg_b_o <= wr_data_i;
			end else if (wr_addr_i == ADDR_FMR) begin
				filter_mode_reg_o <= wr_data_i;
			end else if (wr_addr_i == ADDR_DIAG) begin
				diagnostic_reg_o <= wr_data_i;
			end
		end
	end

	// filter values and mailbox bytes, each guarded by its own state
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			filter_value_o <= '0;
			mbox_data_o <= '0;
		end else begin
			for (int k = 0; k < NUM_FILTERS; k++) begin
				if (wr_en_i && !filter_active_i[k] && wr_addr_i == ADDR_FILT_BASE + 8'(k)) begin
					filter_value_o[8*k +: 8] <= wr_data_i;
				end
			end
			for (int k = 0; k < NUM_MBOX; k++) begin
				if (wr_en_i && mbox_empty_i[k] && wr_addr_i == ADDR_MBOX_BASE + 8'(k)) begin
					mbox_data_o[8*k +: 8] <= wr_data_i;
				end
			end
		end
	end

	// reception tracker: tail counted from the ack, one bit is BIT_CYCLES
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			state_q <= RX_IDLE;
			tail_cnt_q <= '0;
		end else begin
			case (state_q)
				RX_IDLE: begin
					if (rx_sof_i) begin
						state_q <= RX_FRAME;
					end
				end
				RX_FRAME: begin
					if (rx_ack_i) begin
						state_q <= RX_TAIL;
						tail_cnt_q <= '0;
					end
				end
				RX_TAIL: begin
					if (tail_cnt_q == CW'(END_AT - 1)) begin
						state_q <= RX_IDLE;
					end
					tail_cnt_q <= tail_cnt_q + 1'b1;
				end
				default: state_q <= RX_IDLE;
			endcase
		end
	end

	assign receiving_flag_o = (state_q != RX_IDLE);
	// single-cycle transfer strobe, never before six bits plus sample point
	assign xfer = (state_q == RX_TAIL) && (tail_cnt_q == CW'(XFER_AT - 1));
	assign release_req = wr_en_i && (wr_addr_i == ADDR_RFR) && wr_data_i[RFR_RELEASE_BIT];
	// locked on overrun: a message into a full fifo is dropped
	assign push = xfer && (count_q != COUNT_MAX);
	assign pop = release_req && (count_q != COUNT_RESET);
	assign rd_ptr_d = pop ? ((rd_ptr_q == COUNT_MAX - 2'h1) ? 2'h0 : rd_ptr_q + 2'h1) : rd_ptr_q;

	// count and both pointers move together, so a coincident pop and push is safe
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			count_q <= COUNT_RESET;
			rd_ptr_q <= 2'h0;
			wr_ptr_q <= 2'h0;
		end else begin
			if (push && !pop) begin
				count_q <= count_q + 2'h1;
			end else if (pop && !push) begin
				count_q <= count_q - 2'h1;
			end
			rd_ptr_q <= rd_ptr_d;
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == COUNT_MAX - 2'h1) ? 2'h0 : wr_ptr_q + 2'h1;
			end
		end
	end

	assign fifo_pending_count_o = count_q;

	rx_fifo_mem #(
		.WIDTH(MSG_W),
		.DEPTH(3),
		.AW(2)
	) u_mem (
		.ref_clk_i(ref_clk_i),
		.wr_en_i(push),
		.wr_addr_i(wr_ptr_q),
		.wr_data_i(rx_msg_i),
		.rd_addr_i(rd_ptr_d),
		.rd_data_o(fifo_out_msg_o)
	);

	// read mux; release bit always reads back as zero
	always_comb begin
		rd_data_d = 8'h00;
		if (rd_addr_i == ADDR_BTR_LO) begin
			rd_data_d = bit_timing_reg_low_o;
		end else if (rd_addr_i == ADDR_BTR_HI) begin
			rd_data_d = bit_timing_reg_high_o;
		end else if (rd_addr_i == ADDR_FCR_A) begin
			rd_data_d = filter_config_reg_a_o;
		end else if (rd_addr_i == ADDR_FCR_B) begin
			rd_data_d = filter_config_reg_b_o;
		end else if (rd_addr_i == ADDR_FMR) begin
			rd_data_d = filter_mode_reg_o;
		end else if (rd_addr_i == ADDR_DIAG) begin
			rd_data_d = diagnostic_reg_o;
			rd_data_d[DIAG_RX_BIT] = rx_sync_q;
		end else if (rd_addr_i == ADDR_RFR) begin
			rd_data_d[1:0] = count_q;
		end else if (rd_addr_i == ADDR_MSR) begin
			rd_data_d[MSR_RECEIVING_BIT] = receiving_flag_o;
			rd_data_d[MSR_INIT_BIT] = init_mode_i;
		end
	end

	// registered read data
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			rd_data_o <= REG_RESET;
		end else begin
			rd_data_o <= rd_data_d;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);

	property p_timing_locked;
		wr_en_i && !init_mode_i && wr_addr_i == ADDR_BTR_LO |=> $stable(bit_timing_reg_low_o);
	endproperty
	a_timing_locked: assert property (p_timing_locked) else $error("timing reg changed outside init");

	property p_mbox_locked;
		wr_en_i && !mbox_empty_i[0] && wr_addr_i == ADDR_MBOX_BASE |=> $stable(mbox_data_o[7:0]);
	endproperty
	a_mbox_locked: assert property (p_mbox_locked) else $error("busy mailbox modified");

	property p_filter_locked;
		wr_en_i && filter_active_i[0] && wr_addr_i == ADDR_FILT_BASE |=> $stable(filter_value_o[7:0]);
	endproperty
	a_filter_locked: assert property (p_filter_locked) else $error("active filter modified");

	property p_mode_write;
		wr_en_i && init_mode_i && wr_addr_i == ADDR_FMR |=> filter_mode_reg_o == $past(wr_data_i);
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("filter mode write lost in init");

	property p_count_read;
		rd_addr_i == ADDR_RFR |=> rd_data_o == {6'h00, $past(count_q)};
	endproperty
	a_count_read: assert property (p_count_read) else $error("pending count read wrong");

	property p_release_dec;
		pop && !xfer |=> count_q == $past(count_q) - 2'h1;
	endproperty
	a_release_dec: assert property (p_release_dec) else $error("release did not decrement");

	property p_rec_on_sof;
		state_q == RX_IDLE && rx_sof_i |=> receiving_flag_o [*3];
	endproperty
	a_rec_on_sof: assert property (p_rec_on_sof) else $error("receiving flag not raised");

	property p_diag_pin;
		rd_addr_i == ADDR_DIAG |=> rd_data_o[DIAG_RX_BIT] == $past(rx_sync_q);
	endproperty
	a_diag_pin: assert property (p_diag_pin) else $error("diagnostic pin bit wrong");

	property p_xfer_late;
		state_q == RX_FRAME && rx_ack_i |=> !xfer [*8] ##43 !xfer ##1 xfer;
	endproperty
	a_xfer_late: assert property (p_xfer_late) else $error("transfer not at six bits plus sample point");

	property p_coincide;
		push && pop |=> count_q == $past(count_q) && rd_ptr_q != $past(rd_ptr_q) && wr_ptr_q != $past(wr_ptr_q);
	endproperty
	a_coincide: assert property (p_coincide) else $error("coincident release corrupted fifo");

	property p_ptr_count;
		(count_q == COUNT_MAX) ? (wr_ptr_q == rd_ptr_q) :
			(count_q == (wr_ptr_q >= rd_ptr_q ? wr_ptr_q - rd_ptr_q : wr_ptr_q + 2'h3 - rd_ptr_q));
	endproperty
	a_ptr_count: assert property (p_ptr_count) else $error("pointers disagree with count");

	property p_rec_end;
		state_q == RX_TAIL && tail_cnt_q == CW'(END_AT - 1) |=> !receiving_flag_o;
	endproperty
	a_rec_end: assert property (p_rec_end) else $error("receiving flag not cleared");
endmodule
`default_nettype wire

// *** tb/can_bus_node.sv ***
`timescale 1ns/100ps
`default_nettype none
// far-side node: sends one short frame for each start request
module can_bus_node (
	// clock
	input wire logic ref_clk_i,
	// frame request
	input wire logic start_i,
	input wire logic [7:0] msg_i,
	// bus events and receive pin
	output logic rx_sof_o,
	output logic rx_ack_o,
	output logic [7:0] rx_msg_o,
	output logic rx_pin_o
);
	// idle bus is recessive; the message line turns over once its hold is over
	initial begin
		rx_sof_o = 1'b0;
		rx_ack_o = 1'b0;
		rx_msg_o = 8'h00;
		rx_pin_o = 1'b1;
		forever begin
			@(posedge ref_clk_i);
			if (start_i) begin
				@(negedge ref_clk_i);
				rx_sof_o <= 1'b1;
				rx_pin_o <= 1'b0;
				rx_msg_o <= msg_i;
				@(negedge ref_clk_i);
				rx_sof_o <= 1'b0;
				// first level one bit, then two bits each, eight cycles a bit: never five recessive bits
				for (int i = 8; i < 80; i++) begin
					@(negedge ref_clk_i);
					rx_pin_o <= i[4];
				end
				@(negedge ref_clk_i);
				rx_ack_o <= 1'b1;
				rx_pin_o <= 1'b0;
				@(negedge ref_clk_i);
				rx_ack_o <= 1'b0;
				repeat (7) @(negedge ref_clk_i);
				rx_pin_o <= 1'b1;
				repeat (52) @(negedge ref_clk_i);
				rx_msg_o <= ~msg_i;
			end
		end
	end
endmodule
`default_nettype wire

// *** tb/tb_can_config_guard_rx_fifo_release.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_can_config_guard_rx_fifo_release import can_guard_pkg::*;;
	logic ref_clk_i, srst_i, wr_en_i, init_mode_i, rx_sof_i, rx_ack_i, rx_pin_i, receiving_flag_o, start;
	logic [7:0] wr_addr_i, wr_data_i, rd_addr_i, rd_data_o, rx_msg_i, fifo_out_msg_o, msg;
	logic [1:0] mbox_empty_i, filter_active_i, fifo_pending_count_o;
	logic [15:0] filter_value_o, mbox_data_o;
	wire [5:0][7:0] cfg;
	int err_count = 0, n_compared = 0, cycles = 0;
	// narrow messages keep the bench short
	can_config_guard_rx_fifo_release #(.MSG_W(8)) DUT (.ref_clk_i, .srst_i, .wr_en_i, .wr_addr_i, .wr_data_i,
		.rd_addr_i, .rd_data_o, .init_mode_i, .mbox_empty_i, .filter_active_i, .rx_sof_i, .rx_ack_i, .rx_msg_i,
		.rx_pin_i, .bit_timing_reg_low_o(cfg[0]), .bit_timing_reg_high_o(cfg[1]), .filter_config_reg_a_o(cfg[2]),
		.filter_config_reg_b_o(cfg[3]), .filter_mode_reg_o(cfg[4]), .diagnostic_reg_o(cfg[5]), .filter_value_o,
		.mbox_data_o, .fifo_pending_count_o, .receiving_flag_o, .fifo_out_msg_o);
	can_bus_node node (.ref_clk_i, .start_i(start), .msg_i(msg), .rx_sof_o(rx_sof_i), .rx_ack_o(rx_ack_i),
		.rx_msg_o(rx_msg_i), .rx_pin_o(rx_pin_i));
	// 20 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	// hang guard, well above the roughly 1330 cycles the run needs
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			give_verdict();
		end
	end
	task give_verdict;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task chk(input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			$display("unexpected at %0t: exp %h got %h", $time, e, g);
			err_count++;
		end
	endtask
	// starts on a negedge, so back-to-back calls never touch the strobe twice at once
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk_i);
		wr_en_i = 1'b1;
		wr_addr_i = a;
		wr_data_i = d;
		@(negedge ref_clk_i);
		wr_en_i = 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		@(negedge ref_clk_i);
		rd_addr_i = a;
		@(negedge ref_clk_i);
		chk(e, rd_data_o & m);
	endtask
	task t_cfg;
		for (int i = 0; i < 6; i++) begin
			init_mode_i = 1'b0;
			wr(ADDR_BTR_LO + i[7:0], 8'hA5);
			chk(8'h00, cfg[i]);
			init_mode_i = 1'b1;
			wr(ADDR_BTR_LO + i[7:0], 8'h5A);
			chk(8'h5A, cfg[i]);
		end
		$display("t_cfg done");
	endtask
	task t_guard;
		for (int k = 0; k < 2; k++) begin
			wr(ADDR_FILT_BASE + k[7:0], 8'h3C);
			chk(8'h00, filter_value_o[8*k+:8]);
			filter_active_i[k] = 1'b0;
			wr(ADDR_FILT_BASE + k[7:0], 8'h3C);
			chk(8'h3C, filter_value_o[8*k+:8]);
			wr(ADDR_MBOX_BASE + k[7:0], 8'hC3);
			chk(8'h00, mbox_data_o[8*k+:8]);
			mbox_empty_i[k] = 1'b1;
			wr(ADDR_MBOX_BASE + k[7:0], 8'hC3);
			chk(8'hC3, mbox_data_o[8*k+:8]);
		end
		$display("t_guard done");
	endtask
	// one frame; rel puts a release exactly on the transfer cycle
	task automatic frame(input logic [7:0] m, input logic [1:0] c0, input logic [1:0] c1, input logic rel);
		int n;
		n = 0;
		msg = m;
		rd_addr_i = ADDR_DIAG;
		start = 1'b1;
		@(negedge ref_clk_i);
		start = 1'b0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (rx_ack_i !== 1'b1 && n < 200);
		repeat (4) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk(8'h00, rd_data_o & 8'h08);
		rd_addr_i = ADDR_MSR;
		repeat (47) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk({6'h00, c0}, {6'h00, fifo_pending_count_o});
		chk(8'h20, rd_data_o & 8'h20);
		wr_en_i = rel;
		wr_addr_i = ADDR_RFR;
		wr_data_i = 8'h20;
		@(negedge ref_clk_i);
		wr_en_i = 1'b0;
		chk({6'h00, c1}, {6'h00, fifo_pending_count_o});
		repeat (11) @(negedge ref_clk_i);
		chk(8'h01, {7'h00, receiving_flag_o});
		@(negedge ref_clk_i);
		chk(8'h00, {7'h00, receiving_flag_o});
		@(negedge ref_clk_i);
		chk(8'h00, rd_data_o & 8'h20);
	endtask
	task t_fifo;
		rd(ADDR_DIAG, 8'h08, 8'h08);
		frame(8'h11, 2'h0, 2'h1, 1'b0);
		chk(8'h11, fifo_out_msg_o);
		frame(8'h22, 2'h1, 2'h2, 1'b0);
		frame(8'h33, 2'h2, 2'h3, 1'b0);
		frame(8'h44, 2'h3, 2'h3, 1'b0);
		rd(ADDR_RFR, 8'h03, 8'hFF);
		wr(ADDR_RFR, 8'h20);
		chk(8'h02, {6'h00, fifo_pending_count_o});
		chk(8'h22, fifo_out_msg_o);
		$display("t_fifo done");
	endtask
	// release coinciding with a transfer at two pending must not lose a message
	task t_coin;
		frame(8'h55, 2'h2, 2'h2, 1'b1);
		chk(8'h33, fifo_out_msg_o);
		wr(ADDR_RFR, 8'h20);
		chk(8'h55, fifo_out_msg_o);
		chk(8'h01, {6'h00, fifo_pending_count_o});
		wr(ADDR_RFR, 8'h20);
		chk(8'h00, {6'h00, fifo_pending_count_o});
		$display("t_coin done");
	endtask
	// software release by polling around a frame that arrives with two pending; alt is the pin-only sequence
	task automatic poll_frame(input logic [7:0] m, input logic alt);
		int n;
		logic [7:0] v;
		n = 0;
		msg = m;
		start = 1'b1;
		@(negedge ref_clk_i);
		start = 1'b0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (rx_ack_i !== 1'b1 && n < 200);
		// the pin-only sequence starts on the dominant ack, the other once the tail is recessive
		repeat (alt ? 1 : 8) @(negedge ref_clk_i);
		// test and release back to back: any stall here could push the release onto the transfer
		n = 0;
		rd_addr_i = ADDR_RFR;
		@(negedge ref_clk_i);
		v = rd_data_o;
		rd_addr_i = ADDR_MSR;
		@(negedge ref_clk_i);
		if (v[1:0] == 2'h2 && rd_data_o[MSR_RECEIVING_BIT] === 1'b1) begin
			if (alt) begin
				// recessive for over eight bit times means the transfer slot is past
				rd_addr_i = ADDR_DIAG;
				do begin
					@(negedge ref_clk_i);
					n++;
				end while (rd_data_o[DIAG_RX_BIT] === 1'b1 && n <= END_BITS * BIT_CYCLES_MAX_RATE);
			end else begin
				// keep polling while receiving and the pin stays recessive
				do begin
					rd_addr_i = ADDR_DIAG;
					@(negedge ref_clk_i);
					v = rd_data_o;
					rd_addr_i = ADDR_MSR;
					@(negedge ref_clk_i);
					n++;
				end while (v[DIAG_RX_BIT] === 1'b1 && rd_data_o[MSR_RECEIVING_BIT] === 1'b1 && n < 200);
			end
		end
		wr_en_i = 1'b1;
		wr_addr_i = ADDR_RFR;
		wr_data_i = 8'h20;
		@(negedge ref_clk_i);
		wr_en_i = 1'b0;
		n = 0;
		while (receiving_flag_o === 1'b1 && n < 200) begin
			@(negedge ref_clk_i);
			n++;
		end
	endtask
	// both release sequences: the count must end at two and the head must move by one
	task t_poll;
		frame(8'h66, 2'h0, 2'h1, 1'b0);
		frame(8'h77, 2'h1, 2'h2, 1'b0);
		poll_frame(8'h88, 1'b0);
		chk(8'h02, {6'h00, fifo_pending_count_o});
		chk(8'h77, fifo_out_msg_o);
		poll_frame(8'h99, 1'b1);
		chk(8'h02, {6'h00, fifo_pending_count_o});
		chk(8'h88, fifo_out_msg_o);
		$display("t_poll done");
	endtask
	// reset for 8 cycles, then the scenarios
	initial begin
		srst_i = 1'b1;
		wr_en_i = 1'b0;
		wr_addr_i = 8'h00;
		wr_data_i = 8'h00;
		rd_addr_i = 8'h00;
		init_mode_i = 1'b0;
		mbox_empty_i = 2'h0;
		filter_active_i = 2'h3;
		start = 1'b0;
		msg = 8'h00;
		repeat (8) @(negedge ref_clk_i);
		srst_i = 1'b0;
		chk(8'h00, {6'h00, fifo_pending_count_o});
		chk(8'h00, {7'h00, receiving_flag_o});
		t_cfg();
		t_guard();
		t_fifo();
		t_coin();
		t_poll();
		give_verdict();
	end
endmodule
`default_nettype wire
